// *** dv/test_power_mode_sleep_control.sv ***
`timescale 1ns/1ps
module test_power_mode_sleep_control;
  logic                       clk_i;
  logic                       rst_i;
  pm_ctrl_pkg::wb_req_t       wb_req_i;
  logic [31:0]                wb_dat_o;
  logic                       wb_ack_o;
  logic                       wake_irq_i;
  logic                       port_wake_i;
  logic                       sleep_timer_wake_i;
  logic [1:0]                 reset_cause_i;
  logic                       sysclk_source_select_i;
  logic                       cal_busy_i;
  logic                       fast_crystal_osc_ok_i;
  logic                       fast_rc_osc_ok_i;
  logic                       cpu_halt_o;
  logic [1:0]                 power_mode_o;
  logic                       sleep_req_o;
  pm_ctrl_pkg::osc_ctrl_t     osc_ctrl_o;
  logic                       irq_o;
  int                         fail_count = 0;
  int                         cmp_count = 0;

  power_mode_sleep_control power_mode_sleep_control_inst (
    .clk_i                  (clk_i),
    .rst_i                  (rst_i),
    .wb_req_i               (wb_req_i),
    .wb_dat_o               (wb_dat_o),
    .wb_ack_o               (wb_ack_o),
    .wake_irq_i             (wake_irq_i),
    .port_wake_i            (port_wake_i),
    .sleep_timer_wake_i     (sleep_timer_wake_i),
    .reset_cause_i          (reset_cause_i),
    .sysclk_source_select_i (sysclk_source_select_i),
    .cal_busy_i             (cal_busy_i),
    .fast_crystal_osc_ok_i  (fast_crystal_osc_ok_i),
    .fast_rc_osc_ok_i       (fast_rc_osc_ok_i),
    .cpu_halt_o             (cpu_halt_o),
    .power_mode_o           (power_mode_o),
    .sleep_req_o            (sleep_req_o),
    .osc_ctrl_o             (osc_ctrl_o),
    .irq_o                  (irq_o)
  );

  // 125 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////
  // Verdict and comparison helpers
  task automatic give_verdict();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle; returns at the ack edge so callers see its effect next cycle
  task automatic wb(input logic we, input logic [9:0] adr, input logic [7:0] wd,
                    output logic [7:0] rd);
    int n;
    @(posedge clk_i);
    wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: adr, dat: {24'h0, wd}};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      fail_count++;
      $display("Error at %0t: ack missing, got %h, expected %h", $time, wb_ack_o, 1'b1);
      give_verdict();
    end
    rd = wb_dat_o[7:0];
    wb_req_i <= '0;
  endtask : wb

  task automatic wr(input logic [9:0] adr, input logic [7:0] wd);
    logic [7:0] d;
    wb(1'b1, adr, wd, d);
  endtask : wr

  task automatic rdchk(input logic [9:0] adr, input logic [7:0] msk, input logic [7:0] exp);
    logic [7:0] d;
    wb(1'b0, adr, 8'h00, d);
    chk(d & msk, exp);
  endtask : rdchk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  // Reset for 8 cycles; the cause is held so the first edge after release sees it
  task automatic do_reset(input logic [1:0] cause);
    @(posedge clk_i);
    rst_i         <= 1'b1;
    reset_cause_i <= cause;
    cyc(8);
    rst_i         <= 1'b0;
  endtask : do_reset

  ////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_values();
    chk({5'h0, osc_ctrl_o}, 8'h03);
    chk({7'h0, cpu_halt_o}, 8'h00);
    rdchk(pm_ctrl_pkg::PWR_ADDR, 8'hff, 8'h00);
    rdchk(pm_ctrl_pkg::SLEEP_ADDR, 8'hff, 8'h04);
    wr(10'h100, 8'hff);
    rdchk(10'h100, 8'hff, 8'h00);
  endtask : t_reset_values

  // Idle trigger with mode 00: only the core halts, and a wake_irq_i pulse wakes it
  task automatic t_idle();
    wr(pm_ctrl_pkg::IRQ_MASK_ADDR, 8'h01);
    wr(pm_ctrl_pkg::PWR_ADDR, 8'hff);
    @(negedge clk_i);
    chk({7'h0, sleep_req_o}, 8'h01);
    chk({5'h0, cpu_halt_o, power_mode_o}, 8'h04);
    @(negedge clk_i);
    chk({7'h0, sleep_req_o}, 8'h00);
    rdchk(pm_ctrl_pkg::PWR_ADDR, 8'hff, 8'hfc);
    wake_irq_i <= 1'b1;
    @(posedge clk_i);
    wake_irq_i <= 1'b0;
    @(negedge clk_i);
    chk({7'h0, cpu_halt_o}, 8'h00);
    cyc(1);
    chk({7'h0, irq_o}, 8'h01);
    wr(pm_ctrl_pkg::IRQ_STATUS_ADDR, 8'h07);
    rdchk(pm_ctrl_pkg::IRQ_STATUS_ADDR, 8'h07, 8'h00);
  endtask : t_idle

  // Disable waits for the fast RC clock; deep modes lose it, light sleep keeps it
  task automatic t_modes();
    int         i;
    logic [1:0] m;
    wr(pm_ctrl_pkg::SLEEP_ADDR, 8'h84);
    cyc(3);
    chk({7'h0, osc_ctrl_o.cal_enable}, 8'h01);
    sysclk_source_select_i <= 1'b1;
    cyc(3);
    chk({7'h0, osc_ctrl_o.cal_enable}, 8'h00);
    for (i = 1; i < 4; i++) begin
      m = i[1:0];
      wr(pm_ctrl_pkg::SLEEP_ADDR, {6'h21, m});
      wr(pm_ctrl_pkg::PWR_ADDR, 8'h01);
      @(negedge clk_i);
      chk({7'h0, sleep_req_o}, 8'h01);
      chk({5'h0, cpu_halt_o, power_mode_o}, {5'h1, m});
      // The sleep timer has no clock in the deepest mode, so it must not wake
      if (i == 3) begin
        @(posedge clk_i);
        sleep_timer_wake_i <= 1'b1;
        @(posedge clk_i);
        sleep_timer_wake_i <= 1'b0;
        @(negedge clk_i);
        chk({5'h0, cpu_halt_o, power_mode_o}, 8'h07);
      end
      @(posedge clk_i);
      wake_irq_i         <= (i == 1);
      sleep_timer_wake_i <= (i == 2);
      port_wake_i        <= (i == 3);
      @(posedge clk_i);
      {wake_irq_i, sleep_timer_wake_i, port_wake_i} <= 3'h0;
      @(negedge clk_i);
      chk({5'h0, cpu_halt_o, power_mode_o}, 8'h00);
      rdchk(pm_ctrl_pkg::SLEEP_ADDR, (i == 1) ? 8'h84 : 8'h87, (i == 1) ? 8'h84 : 8'h04);
    end
    wr(pm_ctrl_pkg::IRQ_STATUS_ADDR, 8'h07);
  endtask : t_modes

  // Power-down write during calibration is parked until calibration ends
  task automatic t_powerdown();
    wr(pm_ctrl_pkg::SLEEP_ADDR, 8'h04);
    cyc(2);
    chk({5'h0, osc_ctrl_o}, 8'h05);
    cal_busy_i <= 1'b1;
    wr(pm_ctrl_pkg::SLEEP_ADDR, 8'h00);
    cyc(3);
    chk({5'h0, osc_ctrl_o}, 8'h05);
    cal_busy_i <= 1'b0;
    cyc(3);
    chk({5'h0, osc_ctrl_o}, 8'h01);
    wr(pm_ctrl_pkg::SLEEP_ADDR, 8'h04);
    sysclk_source_select_i <= 1'b0;
    cyc(2);
    chk({5'h0, osc_ctrl_o}, 8'h03);
  endtask : t_powerdown

  // Stable flags are read-only and their rising edges raise masked interrupts
  task automatic t_flags();
    wr(pm_ctrl_pkg::IRQ_MASK_ADDR, 8'h02);
    fast_crystal_osc_ok_i <= 1'b1;
    cyc(8);
    wr(pm_ctrl_pkg::SLEEP_ADDR, 8'h24);
    rdchk(pm_ctrl_pkg::SLEEP_ADDR, 8'h60, 8'h40);
    cyc(pm_ctrl_pkg::XTAL_SETTLE_CYC);
    rdchk(pm_ctrl_pkg::SLEEP_ADDR, 8'h40, 8'h40);
    chk({7'h0, irq_o}, 8'h01);
    fast_rc_osc_ok_i <= 1'b1;
    cyc(8);
    rdchk(pm_ctrl_pkg::SLEEP_ADDR, 8'h60, 8'h60);
    chk({7'h0, irq_o}, 8'h01);
    rdchk(pm_ctrl_pkg::IRQ_STATUS_ADDR, 8'h07, 8'h06);
    wr(pm_ctrl_pkg::IRQ_STATUS_ADDR, 8'h06);
    cyc(2);
    chk({7'h0, irq_o}, 8'h00);
    fast_crystal_osc_ok_i <= 1'b0;
    cyc(8);
    rdchk(pm_ctrl_pkg::SLEEP_ADDR, 8'h60, 8'h20);
  endtask : t_flags

  // Cause field follows the latest reset only
  task automatic t_cause();
    do_reset(pm_ctrl_pkg::CAUSE_PIN);
    rdchk(pm_ctrl_pkg::SLEEP_ADDR, 8'h18, 8'h08);
    do_reset(pm_ctrl_pkg::CAUSE_WDOG);
    rdchk(pm_ctrl_pkg::SLEEP_ADDR, 8'h18, 8'h10);
    do_reset(pm_ctrl_pkg::CAUSE_POR);
    rdchk(pm_ctrl_pkg::SLEEP_ADDR, 8'h18, 8'h00);
  endtask : t_cause

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_i                  = 1'b1;
    wb_req_i               = '0;
    {wake_irq_i, port_wake_i, sleep_timer_wake_i} = 3'h0;
    reset_cause_i          = 2'h0;
    sysclk_source_select_i = 1'b0;
    cal_busy_i             = 1'b0;
    fast_crystal_osc_ok_i  = 1'b0;
    fast_rc_osc_ok_i       = 1'b0;
    do_reset(pm_ctrl_pkg::CAUSE_POR);
    t_reset_values();
    t_idle();
    t_modes();
    t_powerdown();
    t_flags();
    t_cause();
    give_verdict();
  end
endmodule : test_power_mode_sleep_control

// *** hw/pm_ctrl_pkg.sv ***
package pm_ctrl_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0]  PWR_IDX         = 8'h87;
  localparam logic [7:0]  SLEEP_IDX       = 8'hbe;
  localparam logic [7:0]  IRQ_STATUS_IDX  = 8'hc0;
  localparam logic [7:0]  IRQ_MASK_IDX    = 8'hc1;
  localparam logic [9:0]  PWR_ADDR        = {PWR_IDX, 2'b00};
  localparam logic [9:0]  SLEEP_ADDR      = {SLEEP_IDX, 2'b00};
  localparam logic [9:0]  IRQ_STATUS_ADDR = {IRQ_STATUS_IDX, 2'b00};
  localparam logic [9:0]  IRQ_MASK_ADDR   = {IRQ_MASK_IDX, 2'b00};

  // Power control register fields
  localparam int          PWR_TRIG_BIT    = 0;
  localparam logic [5:0]  PWR_SPARE_RST   = 6'h00;

  // Sleep control register fields
  localparam int          SLP_CALDIS_BIT  = 7;
  localparam int          SLP_XSTB_BIT    = 6;
  localparam int          SLP_RSTB_BIT    = 5;
  localparam int          SLP_CAUSE_LSB   = 3;
  localparam int          SLP_PD_BIT      = 2;
  localparam int          SLP_MODE_LSB    = 0;
  localparam logic [1:0]  MODE_RST        = 2'h0;
  localparam logic        CALDIS_RST      = 1'b0;
  localparam logic        PD_RST          = 1'b1;

  // Power modes and reset causes
  localparam logic [1:0]  MODE_ACTIVE     = 2'h0;
  localparam logic [1:0]  MODE_LIGHT      = 2'h1;
  localparam logic [1:0]  MODE_TIMED_DEEP = 2'h2;
  localparam logic [1:0]  MODE_DEEPEST    = 2'h3;
  localparam logic [1:0]  CAUSE_POR       = 2'h0;
  localparam logic [1:0]  CAUSE_PIN       = 2'h1;
  localparam logic [1:0]  CAUSE_WDOG      = 2'h2;

  // Interrupt event bits
  localparam int          EV_WAKE         = 0;
  localparam int          EV_XSTB         = 1;
  localparam int          EV_RSTB         = 2;
  localparam int          EV_W            = 3;
  localparam logic [2:0]  EV_RST          = 3'h0;

  // Software settle time after the crystal flag, informative for drivers
  localparam int          XTAL_SETTLE_NS  = 64000;
  localparam int          CLK_PERIOD_NS   = 8;
  localparam int          XTAL_SETTLE_CYC = XTAL_SETTLE_NS / CLK_PERIOD_NS;

  // Gray coded along active -> halted -> sleeping
  typedef enum logic [1:0] {
    ST_ACTIVE   = 2'b00,
    ST_HALTED   = 2'b01,
    ST_SLEEPING = 2'b11
  } pm_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [9:0]  adr;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        crystal_pd;
    logic        fast_rc_pd;
    logic        cal_enable;
  } osc_ctrl_t;

  typedef struct packed {
    pm_state_t   st;
    logic [1:0]  mode;
    logic [5:0]  pwr_spare;
    logic        caldis;
    logic        caldis_eff;
    logic        pd;
    logic        pd_pend;
    logic        pd_pend_v;
    logic [1:0]  cause;
    logic        cause_v;
    logic [2:0]  xsync;
    logic [2:0]  rsync;
    logic        xstb;
    logic        rstb;
    logic [2:0]  ists;
    logic [2:0]  imask;
    logic        ack;
    logic [31:0] dat;
    logic        sleep_req;
  } pm_state_vec_t;

endpackage : pm_ctrl_pkg

// *** hw/power_mode_sleep_control.sv ***
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
module power_mode_sleep_control (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire pm_ctrl_pkg::wb_req_t     wb_req_i,
  output logic [31:0]                   wb_dat_o,
  output logic                          wb_ack_o,
  input  wire logic                     wake_irq_i,
  input  wire logic                     port_wake_i,
  input  wire logic                     sleep_timer_wake_i,
  input  wire logic [1:0]               reset_cause_i,
  input  wire logic                     sysclk_source_select_i,
  input  wire logic                     cal_busy_i,
  input  wire logic                     fast_crystal_osc_ok_i,
  input  wire logic                     fast_rc_osc_ok_i,
  output logic                          cpu_halt_o,
  output logic [1:0]                    power_mode_o,
  output logic                          sleep_req_o,
  output pm_ctrl_pkg::osc_ctrl_t        osc_ctrl_o,
  output logic                          irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State and bus decode

  pm_ctrl_pkg::pm_state_vec_t s_r;
  pm_ctrl_pkg::pm_state_vec_t s_nxt;

  logic       req_live;
  logic       wr_commit;
  logic       wr_pwr;
  logic       wr_sleep;
  logic       wr_ists;
  logic       wr_imask;
  logic       trig_set;
  logic       wake;
  logic [2:0] ev;
  logic [7:0] sleep_rd;

  // Writes land only on the edge where the master sees ack
  assign req_live  = wb_req_i.cyc && wb_req_i.stb;
  assign wr_commit = req_live && wb_req_i.we && s_r.ack && wb_req_i.sel[0];
  assign wr_pwr    = wr_commit && (wb_req_i.adr == pm_ctrl_pkg::PWR_ADDR);
  assign wr_sleep  = wr_commit && (wb_req_i.adr == pm_ctrl_pkg::SLEEP_ADDR);
  assign wr_ists   = wr_commit && (wb_req_i.adr == pm_ctrl_pkg::IRQ_STATUS_ADDR);
  assign wr_imask  = wr_commit && (wb_req_i.adr == pm_ctrl_pkg::IRQ_MASK_ADDR);
  assign trig_set  = wr_pwr && wb_req_i.dat[pm_ctrl_pkg::PWR_TRIG_BIT];

  // Deepest mode ignores the sleep timer; its clock is stopped there
  assign wake = (s_r.st != pm_ctrl_pkg::ST_ACTIVE) &&
                (wake_irq_i || port_wake_i ||
                 (sleep_timer_wake_i && (s_r.mode != pm_ctrl_pkg::MODE_DEEPEST)));

  // Sleep control read image
  always_comb begin
    sleep_rd = 8'h00;
    sleep_rd[pm_ctrl_pkg::SLP_CALDIS_BIT] = s_r.caldis;
    sleep_rd[pm_ctrl_pkg::SLP_XSTB_BIT]   = s_r.xstb;
    sleep_rd[pm_ctrl_pkg::SLP_RSTB_BIT]   = s_r.rstb;
    sleep_rd[pm_ctrl_pkg::SLP_CAUSE_LSB +: 2] = s_r.cause;
    sleep_rd[pm_ctrl_pkg::SLP_PD_BIT]     = s_r.pd;
    sleep_rd[pm_ctrl_pkg::SLP_MODE_LSB +: 2] = s_r.mode;
  end

  // Rises are decoded from the registered flags and the synchroniser so that ev never loops through s_nxt
  assign ev = {(!s_r.rstb && s_r.rsync[1] && s_r.rsync[2]),
               (!s_r.xstb && s_r.xsync[1] && s_r.xsync[2]),
               wake};

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    s_nxt = s_r;
    s_nxt.sleep_req = 1'b0;

    // Oscillator status pins: three flops, a change counts when the last two agree
    s_nxt.xsync = {s_r.xsync[1:0], fast_crystal_osc_ok_i};
    s_nxt.rsync = {s_r.rsync[1:0], fast_rc_osc_ok_i};
    if (s_r.xsync[1] == s_r.xsync[2]) begin
      s_nxt.xstb = s_r.xsync[2];
    end
    if (s_r.rsync[1] == s_r.rsync[2]) begin
      s_nxt.rstb = s_r.rsync[2];
    end

    // Cause is taken once, on the first cycle after reset release
    if (!s_r.cause_v) begin
      s_nxt.cause   = reset_cause_i;
      s_nxt.cause_v = 1'b1;
    end

    // Power mode sequencer
    case (s_r.st)
      pm_ctrl_pkg::ST_ACTIVE: begin
        if (trig_set) begin
          s_nxt.sleep_req = 1'b1;
          if (s_r.mode == pm_ctrl_pkg::MODE_ACTIVE) begin
            s_nxt.st = pm_ctrl_pkg::ST_HALTED;
          end else begin
            s_nxt.st = pm_ctrl_pkg::ST_SLEEPING;
          end
        end
      end
      pm_ctrl_pkg::ST_HALTED: begin
        if (wake) begin
          s_nxt.st = pm_ctrl_pkg::ST_ACTIVE;
        end
      end
      pm_ctrl_pkg::ST_SLEEPING: begin
        if (wake) begin
          s_nxt.st   = pm_ctrl_pkg::ST_ACTIVE;
          s_nxt.mode = pm_ctrl_pkg::MODE_ACTIVE;
          if (s_r.mode[1]) begin
            s_nxt.caldis     = pm_ctrl_pkg::CALDIS_RST;
            s_nxt.caldis_eff = pm_ctrl_pkg::CALDIS_RST;
          end
        end
      end
      default: begin
        s_nxt.st = pm_ctrl_pkg::ST_ACTIVE;
      end
    endcase

    // Register writes
    if (wr_pwr) begin
      s_nxt.pwr_spare = wb_req_i.dat[7:2];
    end
    if (wr_sleep) begin
      s_nxt.caldis = wb_req_i.dat[pm_ctrl_pkg::SLP_CALDIS_BIT];
      if (s_r.st == pm_ctrl_pkg::ST_ACTIVE) begin
        s_nxt.mode = wb_req_i.dat[pm_ctrl_pkg::SLP_MODE_LSB +: 2];
      end
      // A write racing the calibration is parked, not dropped
      if (cal_busy_i) begin
        s_nxt.pd_pend   = wb_req_i.dat[pm_ctrl_pkg::SLP_PD_BIT];
        s_nxt.pd_pend_v = 1'b1;
      end else begin
        s_nxt.pd        = wb_req_i.dat[pm_ctrl_pkg::SLP_PD_BIT];
        s_nxt.pd_pend_v = 1'b0;
      end
    end else if (s_r.pd_pend_v && !cal_busy_i) begin
      s_nxt.pd        = s_r.pd_pend;
      s_nxt.pd_pend_v = 1'b0;
    end

    // Clearing to 0 is immediate; setting waits for the fast RC clock source
    if (!s_nxt.caldis) begin
      s_nxt.caldis_eff = 1'b0;
    end else if (sysclk_source_select_i) begin
      s_nxt.caldis_eff = 1'b1;
    end

    // Interrupt status: a new event beats a write-one clear in the same cycle
    if (wr_imask) begin
      s_nxt.imask = wb_req_i.dat[2:0];
    end
    if (wr_ists) begin
      s_nxt.ists = s_r.ists & ~wb_req_i.dat[2:0];
    end
    s_nxt.ists = s_nxt.ists | ev;

    // Bus: ack one cycle after the request, drop it the cycle after
    s_nxt.ack = req_live && !s_r.ack;
    if (req_live && !s_r.ack) begin
      s_nxt.dat = 32'h0000_0000;
      case (wb_req_i.adr)
        pm_ctrl_pkg::PWR_ADDR: begin
          s_nxt.dat[7:2] = s_r.pwr_spare;
        end
        pm_ctrl_pkg::SLEEP_ADDR: begin
          s_nxt.dat[7:0] = sleep_rd;
        end
        pm_ctrl_pkg::IRQ_STATUS_ADDR: begin
          s_nxt.dat[2:0] = s_r.ists;
        end
        pm_ctrl_pkg::IRQ_MASK_ADDR: begin
          s_nxt.dat[2:0] = s_r.imask;
        end
        default: begin
          s_nxt.dat = 32'h0000_0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r            <= '0;
      s_r.st         <= pm_ctrl_pkg::ST_ACTIVE;
      s_r.mode       <= pm_ctrl_pkg::MODE_RST;
      s_r.pwr_spare  <= pm_ctrl_pkg::PWR_SPARE_RST;
      s_r.caldis     <= pm_ctrl_pkg::CALDIS_RST;
      s_r.caldis_eff <= pm_ctrl_pkg::CALDIS_RST;
      s_r.pd         <= pm_ctrl_pkg::PD_RST;
      s_r.cause      <= pm_ctrl_pkg::CAUSE_POR;
      s_r.ists       <= pm_ctrl_pkg::EV_RST;
      s_r.imask      <= pm_ctrl_pkg::EV_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Sleep states leave the fast oscillators running; only pd with sysclk_source_select_i stops one of them
  assign cpu_halt_o   = (s_r.st != pm_ctrl_pkg::ST_ACTIVE);
  assign power_mode_o = (s_r.st == pm_ctrl_pkg::ST_SLEEPING) ? s_r.mode
                                                             : pm_ctrl_pkg::MODE_ACTIVE;
  assign sleep_req_o  = s_r.sleep_req;
  assign osc_ctrl_o.crystal_pd = s_r.pd && sysclk_source_select_i;
  assign osc_ctrl_o.fast_rc_pd = s_r.pd && !sysclk_source_select_i;
  assign osc_ctrl_o.cal_enable = !s_r.caldis_eff;
  assign irq_o        = |(s_r.ists & s_r.imask);
  assign wb_ack_o     = s_r.ack;
  assign wb_dat_o     = s_r.dat;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_trig_write;
    trig_set && (s_r.st == pm_ctrl_pkg::ST_ACTIVE);
  endsequence

  sequence s_one_pulse;
    sleep_req_o ##1 !sleep_req_o;
  endsequence

  property p_pwr_reads_zero;
    req_live && !wb_req_i.we && !s_r.ack && (wb_req_i.adr == pm_ctrl_pkg::PWR_ADDR)
      |=> wb_ack_o && (wb_dat_o[1:0] == 2'h0);
  endproperty
  a_pwr_reads_zero: assert property (p_pwr_reads_zero)
    else $error("trigger or bit 1 read back nonzero");

  property p_enter_pulse;
    s_trig_write |=> s_one_pulse;
  endproperty
  a_enter_pulse: assert property (p_enter_pulse)
    else $error("trigger did not yield a single request pulse");

  property p_enter_mode;
    s_trig_write ##0 (s_r.mode != pm_ctrl_pkg::MODE_ACTIVE)
      |=> cpu_halt_o && (power_mode_o == $past(s_r.mode));
  endproperty
  a_enter_mode: assert property (p_enter_mode)
    else $error("selected mode not entered");

  property p_halt_only;
    s_trig_write ##0 (s_r.mode == pm_ctrl_pkg::MODE_ACTIVE)
      |=> cpu_halt_o && (power_mode_o == pm_ctrl_pkg::MODE_ACTIVE);
  endproperty
  a_halt_only: assert property (p_halt_only)
    else $error("mode 00 trigger did more than halt the core");

  property p_irq_wakes;
    cpu_halt_o && wake_irq_i |=> !cpu_halt_o && (power_mode_o == pm_ctrl_pkg::MODE_ACTIVE);
  endproperty
  a_irq_wakes: assert property (p_irq_wakes)
    else $error("enabled interrupt did not return to active");

  property p_mode_cleared;
    (s_r.st == pm_ctrl_pkg::ST_SLEEPING) && port_wake_i |=> (s_r.mode == 2'h0);
  endproperty
  a_mode_cleared: assert property (p_mode_cleared)
    else $error("mode field not cleared on wake");

  property p_caldis_gated;
    $rose(s_r.caldis_eff) |-> $past(sysclk_source_select_i) && s_r.caldis;
  endproperty
  a_caldis_gated: assert property (p_caldis_gated)
    else $error("calibration disabled without fast RC source");

  property p_caldis_lost;
    (s_r.st == pm_ctrl_pkg::ST_SLEEPING) && s_r.mode[1] && wake |=> !s_r.caldis;
  endproperty
  a_caldis_lost: assert property (p_caldis_lost)
    else $error("calibration disable kept through deep mode");

  property p_pd_deferred;
    $changed(s_r.pd) |-> !$past(cal_busy_i);
  endproperty
  a_pd_deferred: assert property (p_pd_deferred)
    else $error("power-down bit moved during calibration");

  property p_cause_latch;
    !s_r.cause_v ##1 s_r.cause_v |-> s_r.cause == $past(reset_cause_i);
  endproperty
  a_cause_latch: assert property (p_cause_latch)
    else $error("reset cause not the latest");

  property p_pd_select;
    s_r.pd |-> (osc_ctrl_o.crystal_pd != osc_ctrl_o.fast_rc_pd);
  endproperty
  a_pd_select: assert property (p_pd_select)
    else $error("power-down did not stop exactly one oscillator");

  property p_pd_off;
    !s_r.pd |-> !osc_ctrl_o.crystal_pd && !osc_ctrl_o.fast_rc_pd;
  endproperty
  a_pd_off: assert property (p_pd_off)
    else $error("oscillator stopped with power-down bit clear");

  property p_caldis_clear;
    wr_sleep && !wb_req_i.dat[pm_ctrl_pkg::SLP_CALDIS_BIT] |=> osc_ctrl_o.cal_enable;
  endproperty
  a_caldis_clear: assert property (p_caldis_clear)
    else $error("calibration not enabled after writing zero");

  property p_deep_timer;
    (s_r.st == pm_ctrl_pkg::ST_SLEEPING) && (s_r.mode == pm_ctrl_pkg::MODE_DEEPEST) &&
      sleep_timer_wake_i && !wake_irq_i && !port_wake_i |=> cpu_halt_o;
  endproperty
  a_deep_timer: assert property (p_deep_timer)
    else $error("sleep timer woke the deepest mode");

  property p_xstb_low;
    (s_r.xsync[2:1] == 2'b00) |=> !s_r.xstb;
  endproperty
  a_xstb_low: assert property (p_xstb_low)
    else $error("crystal flag set while the oscillator is not stable");

  property p_rstb_high;
    (s_r.rsync[2:1] == 2'b11) |=> s_r.rstb;
  endproperty
  a_rstb_high: assert property (p_rstb_high)
    else $error("fast RC flag not set once the oscillator is stable");

endmodule : power_mode_sleep_control
